// ### logic/pcs_sequencer.sv
/*
  Instruction address sequencer: ten-bit instruction address counter with
  step, branch, call, return, table read and interrupt vectoring, plus the
  pointer of a five-entry return-address stack.
  Assumes decode presents one operation per completed instruction on the
  core clock and keeps nesting within five levels.
*/
// Function
// (R1) Instruction address counter is a ten-bit binary counter addressing program memory.
// (R2) Counter increments once per completed instruction unless something loads it.
// (R3) Reset low clears the counter so execution starts at zero.
// (R4) Direct branch loads operand address, nothing saved.
// (R5) Indirect branch copies address pointer register bit for bit.
// (R6) Direct call pushes next address, then loads operand address.
// (R7) Indirect call pushes next address, then loads pointer register value.
// (R8) Return stack has five entries, indices 0 to 4, ten bits each.
// (R9) Table read drives the pointer register value onto the counter.
// (R10) Accepted interrupt loads the vector of its source.
// (R11) All three returns reload the counter from the top stack entry.
// (R12) Accepted interrupt saves the counter plus one onto the stack in the same cycle as it vectors.
// (R13) Vectors: serial 1, timer 2, external 3, reset 0.
// (R14) Table read borrows one stack entry, fetches to data buffer, restores.
// (R15) Pushed value is the address that would execute next.
// (R16) Push advances stack pointer, return retreats it; overflow unguarded.
`timescale 1ns/100ps
module pcs_sequencer (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic CLK_EN,
  input wire logic INSTR_DONE,
  input wire pcs_pkg::pcs_op_t OP,
  input wire logic [9:0] OPERAND_ADDR,
  input wire logic [9:0] ADDRESS_POINTER_REG,
  input wire logic IRQ_ACCEPT,
  input wire pcs_pkg::pcs_irq_t IRQ_SRC,
  input wire logic [15:0] PROG_DATA,
  output logic [9:0] INSTR_ADDRESS_COUNTER,
  output logic [15:0] DATA_BUFFER_REG,
  output logic DATA_BUFFER_VALID,
  output logic BUSY,
  output logic [2:0] STACK_PTR
);
  // ****************************************
  // Reset release
  // ****************************************
  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  function automatic logic [9:0] vector_of(input pcs_pkg::pcs_irq_t src);
    case (src)
      pcs_pkg::PCS_IRQ_SERIAL: vector_of = pcs_pkg::VEC_SERIAL; // [R13]
      pcs_pkg::PCS_IRQ_TIMER: vector_of = pcs_pkg::VEC_TIMER; // [R13]
      pcs_pkg::PCS_IRQ_EXTINT: vector_of = pcs_pkg::VEC_EXTINT; // [R13]
      default: vector_of = pcs_pkg::VEC_EXTINT;
    endcase
  endfunction

  // ****************************************
  // Sequencer state
  // ****************************************
  // Table read: RUN -> FETCH (address on counter) -> CAPTURE (data buffer) -> RESTORE (stack word back)
  typedef enum logic [1:0] {ST_RUN, ST_FETCH, ST_CAPTURE, ST_RESTORE} pcs_state_t;
  pcs_state_t state_q, state_d;
  logic [9:0] pc_q, pc_d;
  logic [2:0] sp_q, sp_d;
  logic [15:0] dbf_q, dbf_d;
  logic dbv_q, dbv_d;
  logic busy_q, busy_d;
  logic push;
  logic [9:0] push_data;
  logic [2:0] rd_idx;
  logic [9:0] stack_rd;
  logic [9:0] pc_next;

  assign pc_next = pc_q + 10'h001; // [R15]
  // Read index follows the next pointer, so back to back returns see the new top
  assign rd_idx = sp_d - 3'h1;

  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    sp_d = sp_q;
    dbf_d = dbf_q;
    dbv_d = 1'b0;
    push = 1'b0;
    push_data = pc_next;
    case (state_q)
      ST_RUN: begin
        if (INSTR_DONE && IRQ_ACCEPT) begin
          // Interrupt takes over; the completed instruction's successor resumes
          push = 1'b1; // [R12]
          sp_d = sp_q + 3'h1; // [R16]
          pc_d = vector_of(IRQ_SRC); // [R10]
        end else if (INSTR_DONE) begin
          case (OP)
            pcs_pkg::PCS_OP_BRANCH_DIR: pc_d = OPERAND_ADDR; // [R4]
            pcs_pkg::PCS_OP_BRANCH_IND: pc_d = ADDRESS_POINTER_REG; // [R5]
            pcs_pkg::PCS_OP_CALL_DIR: begin
              push = 1'b1; // [R6]
              sp_d = sp_q + 3'h1; // [R16]
              pc_d = OPERAND_ADDR; // [R6]
            end
            pcs_pkg::PCS_OP_CALL_IND: begin
              push = 1'b1; // [R7]
              sp_d = sp_q + 3'h1; // [R16]
              pc_d = ADDRESS_POINTER_REG; // [R7]
            end
            pcs_pkg::PCS_OP_RETURN, pcs_pkg::PCS_OP_RETURN_SKIP, pcs_pkg::PCS_OP_RETURN_INT: begin
              pc_d = stack_rd; // [R11]
              sp_d = sp_q - 3'h1; // [R16]
            end
            pcs_pkg::PCS_OP_TABLE_READ: begin
              push = 1'b1; // [R14]
              sp_d = sp_q + 3'h1; // [R16]
              pc_d = ADDRESS_POINTER_REG; // [R9]
              state_d = ST_FETCH;
            end
            default: pc_d = pc_next; // [R2]
          endcase
        end
      end
      ST_FETCH: begin
        // Program memory answers one cycle after the address is shown
        state_d = ST_CAPTURE;
      end
      ST_CAPTURE: begin
        dbf_d = PROG_DATA; // [R14]
        dbv_d = 1'b1;
        state_d = ST_RESTORE;
      end
      ST_RESTORE: begin
        pc_d = stack_rd; // [R14]
        sp_d = sp_q - 3'h1; // [R16]
        state_d = ST_RUN;
      end
      default: state_d = ST_RUN;
    endcase
    // Registered so the busy output comes straight from a flop
    busy_d = (state_d != ST_RUN);
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_RUN;
      pc_q <= pcs_pkg::RESET_ADDR; // [R3]
      sp_q <= pcs_pkg::SP_RESET;
      dbf_q <= 16'h0000;
      dbv_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (CLK_EN) begin
      state_q <= state_d;
      pc_q <= pc_d; // [R1]
      sp_q <= sp_d;
      dbf_q <= dbf_d;
      dbv_q <= dbv_d;
      busy_q <= busy_d;
    end
  end

  pcs_stack u_stack ( // [R8]
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .en(CLK_EN),
    .wr_en(push),
    .wr_idx(sp_q),
    .wr_data(push_data),
    .rd_idx(rd_idx),
    .rd_data_q(stack_rd)
  );

  // Registered read lags one cycle: returns must not follow a push back to back
  assign INSTR_ADDRESS_COUNTER = pc_q;
  assign DATA_BUFFER_REG = dbf_q;
  assign DATA_BUFFER_VALID = dbv_q;
  assign BUSY = busy_q;
  assign STACK_PTR = sp_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!rst_n);

  sequence s_tbl_start;
    CLK_EN && state_q == ST_RUN && INSTR_DONE && !IRQ_ACCEPT && OP == pcs_pkg::PCS_OP_TABLE_READ;
  endsequence

  step_incr_a: assert property (CLK_EN && state_q == ST_RUN && INSTR_DONE && !IRQ_ACCEPT // [R2]
    && OP == pcs_pkg::PCS_OP_STEP |=> pc_q == $past(pc_q) + 10'h001) else $error("step mismatch");
  br_dir_a: assert property (CLK_EN && state_q == ST_RUN && INSTR_DONE && !IRQ_ACCEPT // [R4]
    && OP == pcs_pkg::PCS_OP_BRANCH_DIR |=> pc_q == $past(OPERAND_ADDR) && sp_q == $past(sp_q))
    else $error("direct branch wrong");
  br_ind_a: assert property (CLK_EN && state_q == ST_RUN && INSTR_DONE && !IRQ_ACCEPT // [R5]
    && OP == pcs_pkg::PCS_OP_BRANCH_IND |=> pc_q == $past(ADDRESS_POINTER_REG))
    else $error("indirect branch wrong");
  call_push_a: assert property (CLK_EN && state_q == ST_RUN && INSTR_DONE && !IRQ_ACCEPT // [R6]
    && OP == pcs_pkg::PCS_OP_CALL_DIR |=> sp_q == $past(sp_q) + 3'h1 && pc_q == $past(OPERAND_ADDR))
    else $error("call push wrong");
  call_ind_a: assert property (CLK_EN && state_q == ST_RUN && INSTR_DONE && !IRQ_ACCEPT // [R7]
    && OP == pcs_pkg::PCS_OP_CALL_IND |=> sp_q == $past(sp_q) + 3'h1 && pc_q == $past(ADDRESS_POINTER_REG))
    else $error("indirect call wrong");
  ret_pop_a: assert property (CLK_EN && state_q == ST_RUN && INSTR_DONE && !IRQ_ACCEPT // [R16]
    && (OP == pcs_pkg::PCS_OP_RETURN || OP == pcs_pkg::PCS_OP_RETURN_SKIP || OP == pcs_pkg::PCS_OP_RETURN_INT)
    |=> sp_q == $past(sp_q) - 3'h1) else $error("return pop wrong");
  irq_vec_a: assert property (CLK_EN && state_q == ST_RUN && INSTR_DONE && IRQ_ACCEPT // [R10]
    && IRQ_SRC == pcs_pkg::PCS_IRQ_TIMER |=> pc_q == pcs_pkg::VEC_TIMER && sp_q == $past(sp_q) + 3'h1)
    else $error("interrupt vector wrong");
  tbl_seq_a: assert property (s_tbl_start ##1 CLK_EN [*3] |-> ##1 pc_q == $past(pc_q, 4) + 10'h001 // [R14]
    && sp_q == $past(sp_q, 4)) else $error("table read restore wrong");
  tbl_addr_a: assert property (s_tbl_start |=> pc_q == $past(ADDRESS_POINTER_REG)) // [R9]
    else $error("table address wrong");
  tbl_busy_a: assert property (s_tbl_start |=> BUSY) // [R14]
    else $error("busy missing in table read");
  hold_en_a: assert property (!CLK_EN |=> pc_q == $past(pc_q) && sp_q == $past(sp_q)) // [R1]
    else $error("state moved while disabled");
endmodule // pcs_sequencer

// ### logic/pcs_pkg.sv
/*
  Constants for the instruction address sequencer: widths, stack depth,
  interrupt vectors and the operation codes driven by decode logic.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pcs_pkg;
  localparam int ADDR_W = 10;
  localparam int STACK_DEPTH = 5;
  localparam int SP_W = 3;
  localparam logic [9:0] RESET_ADDR = 10'h000;
  localparam logic [9:0] VEC_SERIAL = 10'h001;
  localparam logic [9:0] VEC_TIMER = 10'h002;
  localparam logic [9:0] VEC_EXTINT = 10'h003;
  localparam logic [2:0] SP_RESET = 3'h0;
  localparam logic [2:0] SP_TOP = 3'h4;

  // Operation requested by decode for the completing instruction
  typedef enum logic [3:0] {
    PCS_OP_NONE = 4'h0,
    PCS_OP_STEP = 4'h1,
    PCS_OP_BRANCH_DIR = 4'h2,
    PCS_OP_BRANCH_IND = 4'h3,
    PCS_OP_CALL_DIR = 4'h4,
    PCS_OP_CALL_IND = 4'h5,
    PCS_OP_RETURN = 4'h6,
    PCS_OP_RETURN_SKIP = 4'h7,
    PCS_OP_RETURN_INT = 4'h8,
    PCS_OP_TABLE_READ = 4'h9
  } pcs_op_t;

  // Interrupt source selector
  typedef enum logic [1:0] {
    PCS_IRQ_SERIAL = 2'h0,
    PCS_IRQ_TIMER = 2'h1,
    PCS_IRQ_EXTINT = 2'h2
  } pcs_irq_t;
endpackage

// ### logic/pcs_stack.sv
/*
  Return-address stack storage: five words of ten bits, one write port and
  one registered read port.
  Assumes the caller keeps the index in range and handles pointer updates.
*/
`timescale 1ns/100ps
module pcs_stack (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [9:0] wr_data,
  input wire logic [2:0] rd_idx,
  output logic [9:0] rd_data_q
);
  logic [9:0] mem_q [pcs_pkg::STACK_DEPTH];
  logic [9:0] rd_data_d;

  always_comb begin
    rd_data_d = rd_data_q;
    if (en) begin
      rd_data_d = (rd_idx <= pcs_pkg::SP_TOP) ? mem_q[rd_idx] : pcs_pkg::RESET_ADDR;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= 10'h000;
      for (int i = 0; i < pcs_pkg::STACK_DEPTH; i++) begin
        mem_q[i] <= 10'h000;
      end
    end else begin
      rd_data_q <= rd_data_d;
      if (en && wr_en && wr_idx <= pcs_pkg::SP_TOP) begin
        mem_q[wr_idx] <= wr_data;
      end
    end
  end
endmodule // pcs_stack

// ### bench/pcs_prog_mem.sv
/*
  Program memory model: one 16-bit word per address, read one cycle late.
  Assumes the address comes from the sequencer on the core clock.
*/
`timescale 1ns/100ps
module pcs_prog_mem (
  input wire logic clk,
  input wire logic [9:0] addr,
  output logic [15:0] data
);
  // Registered read, no kinder than a synchronous array
  always_ff @(posedge clk) begin
    data <= {6'h2c, addr ^ 10'h3c3};
  end
endmodule // pcs_prog_mem

// ### bench/pcs_sequencer_tb_top.sv
/*
  Self-checking bench for the address sequencer with a memory model.
  Assumes pcs_pkg and the design files are compiled first.
*/
`timescale 1ns/100ps
module pcs_sequencer_tb_top;
  logic clk = 0;
  logic nrst = 0;
  logic done = 0;
  logic irq = 0;
  logic en = 1'b1;
  pcs_pkg::pcs_op_t op = pcs_pkg::PCS_OP_NONE;
  pcs_pkg::pcs_irq_t src = pcs_pkg::PCS_IRQ_SERIAL;
  logic [9:0] opa = 10'h000;
  logic [9:0] ptr = 10'h000;
  logic [9:0] pc;
  logic [15:0] pd;
  logic [15:0] dbuf;
  logic dv;
  logic busy;
  logic [2:0] sp;
  int miscompares = 0;
  int checks = 0;

  pcs_sequencer DUT (.CORE_CLK(clk), .NRST(nrst), .CLK_EN(en), .INSTR_DONE(done), .OP(op),
    .OPERAND_ADDR(opa), .ADDRESS_POINTER_REG(ptr), .IRQ_ACCEPT(irq), .IRQ_SRC(src), .PROG_DATA(pd),
    .INSTR_ADDRESS_COUNTER(pc), .DATA_BUFFER_REG(dbuf), .DATA_BUFFER_VALID(dv), .BUSY(busy),
    .STACK_PTR(sp));
  pcs_prog_mem mem (.clk(clk), .addr(pc), .data(pd));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // One completed instruction; returns at the negedge after it is taken
  task automatic issue(input pcs_pkg::pcs_op_t o, input logic i);
    @(negedge clk);
    done = 1'b1;
    op = o;
    irq = i;
    @(negedge clk);
    done = 1'b0;
    irq = 1'b0;
  endtask

  task automatic t_branch;
    check(16'(pc), 16'h0000);
    issue(pcs_pkg::PCS_OP_STEP, 1'b0);
    check(16'(pc), 16'h0001);
    issue(pcs_pkg::PCS_OP_NONE, 1'b0);
    check(16'(pc), 16'h0002);
    opa = 10'h3ff;
    issue(pcs_pkg::PCS_OP_BRANCH_DIR, 1'b0);
    check(16'({sp, pc}), 16'h03ff);
    issue(pcs_pkg::PCS_OP_STEP, 1'b0);
    check(16'(pc), 16'h0000);
    ptr = 10'h2a5;
    issue(pcs_pkg::PCS_OP_BRANCH_IND, 1'b0);
    check(16'(pc), 16'h02a5);
  endtask

  // Enable low swallows a completed call: nothing moves
  task automatic t_hold;
    logic [9:0] was;
    was = pc;
    en = 1'b0;
    opa = 10'h0aa;
    issue(pcs_pkg::PCS_OP_CALL_DIR, 1'b0);
    check(16'({busy, sp, pc}), 16'(was));
    en = 1'b1;
    issue(pcs_pkg::PCS_OP_STEP, 1'b0);
    check(16'({sp, pc}), 16'(was + 10'h001));
  endtask

  // Reset in mid-run from a non-zero counter
  task automatic t_reset;
    nrst = 1'b0;
    @(negedge clk);
    check(16'({busy, sp, pc}), 16'h0000);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    issue(pcs_pkg::PCS_OP_STEP, 1'b0);
    check(16'({sp, pc}), 16'h0001);
  endtask

  task automatic call_ret(input pcs_pkg::pcs_op_t c, input pcs_pkg::pcs_op_t r, input logic i,
    input logic [9:0] tgt);
    logic [9:0] nxt;
    nxt = pc + 10'h001;
    issue(c, i);
    check(16'({sp, pc}), 16'({3'h1, tgt}));
    issue(r, 1'b0);
    check(16'({sp, pc}), 16'(nxt));
  endtask

  task automatic t_nest;
    logic [9:0] ret [5];
    for (int k = 0; k < 5; k++) begin
      ret[k] = pc + 10'h001;
      opa = 10'(64 * (k + 1));
      issue(pcs_pkg::PCS_OP_CALL_DIR, 1'b0);
      check(16'(sp), 16'(k + 1));
    end
    for (int k = 4; k >= 0; k--) begin
      issue(pcs_pkg::PCS_OP_RETURN, 1'b0);
      check(16'(pc), 16'(ret[k]));
    end
  endtask

  task automatic t_table;
    logic [9:0] nxt;
    nxt = pc + 10'h001;
    ptr = 10'h123;
    issue(pcs_pkg::PCS_OP_TABLE_READ, 1'b0);
    check(16'({busy, sp, pc}), 16'h2523);
    for (int k = 0; k < 4 && dv !== 1'b1; k++) @(negedge clk);
    check(16'(dv), 16'h0001);
    check(dbuf, {6'h2c, 10'h123 ^ 10'h3c3});
    @(negedge clk);
    check(16'({dv, busy, sp, pc}), 16'(nxt));
  endtask

  initial begin
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    t_branch();
    t_hold();
    opa = 10'h155;
    call_ret(pcs_pkg::PCS_OP_CALL_DIR, pcs_pkg::PCS_OP_RETURN, 1'b0, 10'h155);
    call_ret(pcs_pkg::PCS_OP_CALL_IND, pcs_pkg::PCS_OP_RETURN_SKIP, 1'b0, 10'h2a5);
    src = pcs_pkg::PCS_IRQ_SERIAL;
    call_ret(pcs_pkg::PCS_OP_NONE, pcs_pkg::PCS_OP_RETURN_INT, 1'b1, 10'h001);
    src = pcs_pkg::PCS_IRQ_TIMER;
    call_ret(pcs_pkg::PCS_OP_BRANCH_DIR, pcs_pkg::PCS_OP_RETURN_INT, 1'b1, 10'h002);
    src = pcs_pkg::PCS_IRQ_EXTINT;
    call_ret(pcs_pkg::PCS_OP_STEP, pcs_pkg::PCS_OP_RETURN_INT, 1'b1, 10'h003);
    t_nest();
    t_table();
    t_reset();
    results();
  end

  // Whole run is under a hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    results();
  end
endmodule // pcs_sequencer_tb_top
